// file: rtl/host_debug_byte_fifo_defines.vh
// Constants used by the host debug byte capture block, not by its queue.
`ifndef HOST_DEBUG_BYTE_FIFO_DEFINES_VH
`define HOST_DEBUG_BYTE_FIFO_DEFINES_VH

// ----------------------------------------------------------------------
// Controller-side register offsets (byte addresses).
// ----------------------------------------------------------------------
`define OFS_QUEUED_ENTRY_READ   12'h100
`define OFS_CAPTURE_SETUP       12'h104
`define OFS_QUEUE_FLAGS         12'h108
`define OFS_TICK_COUNTER_VALUE  12'h10C
`define OFS_BLOCK_ACTIVATION    12'h330

// ----------------------------------------------------------------------
// Host-side offsets and configuration port index.
// ----------------------------------------------------------------------
`define OFS_HOST_DEBUG_BYTE     8'h00
`define IDX_BLOCK_ACTIVATION    8'h30

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define BIT_ACTIVATE            0
`define BIT_FLUSH               1
`define BIT_STAMP_CLEAR         2
`define POS_TICK_RATE_LO        3
`define POS_TICK_RATE_HI        4
`define BIT_TIMER_ENABLE        5
`define POS_THRESHOLD_LO        6
`define POS_THRESHOLD_HI        7
`define BIT_HAS_ENTRIES         0
`define BIT_OVERRUN             1

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define RST_SETUP_FIELDS        2'h0
`define RST_STAMP               24'h000000
`define RST_WORD                32'h00000000

// ----------------------------------------------------------------------
// Threshold levels, in entries.
// ----------------------------------------------------------------------
`define THR_LEVEL_0             5'h01
`define THR_LEVEL_1             5'h04
`define THR_LEVEL_2             5'h08
`define THR_LEVEL_3             5'h0E

// ----------------------------------------------------------------------
// Tick prescaler terminal counts (division ratio minus one).
// ----------------------------------------------------------------------
`define DIV_LAST_8              6'h07
`define DIV_LAST_16             6'h0F
`define DIV_LAST_32             6'h1F
`define DIV_LAST_64             6'h3F

`endif

// file: rtl/entry_queue.v
// Synchronous first-in first-out queue with valid and ready on both sides.
`timescale 1ns/1ps

module entry_queue #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             ce,
  input  wire             flush,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0]      level
);

  // ----------------------------------------------------------------------
  // Storage and pointers.
  // ----------------------------------------------------------------------
  localparam [AW:0] FULL_LVL = DEPTH[AW:0]; // Level at which no slot is free.

  reg [WIDTH-1:0] mem [0:DEPTH-1];      // Entry storage.
  reg [AW-1:0]    wr_ptr_reg;           // Next slot to fill.
  reg [AW-1:0]    rd_ptr_reg;           // Oldest entry.
  reg [AW:0]      count_reg;            // Entries held.

  wire full = (count_reg == FULL_LVL);  // No free slot.
  wire push;                            // Entry accepted.
  wire pop;                             // Entry removed.

  // A push into a full queue is allowed only when a pop frees a slot
  // in the same cycle; otherwise the writer is stalled.
  assign in_ready  = !full || out_ready;
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_reg];
  assign level     = count_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage is written without reset, which keeps it a plain memory.
  always @(posedge clk) begin
    if (ce && push && !flush) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointer and level bookkeeping; a flush wins over a push or a pop.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (flush) begin
        wr_ptr_reg <= {AW{1'b0}};
        rd_ptr_reg <= {AW{1'b0}};
        count_reg  <= {(AW+1){1'b0}};
      end else begin
        if (push) begin
          wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
        if (pop) begin
          rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
        if (push && !pop) begin
          count_reg <= count_reg + 1'b1;
        end else if (pop && !push) begin
          count_reg <= count_reg - 1'b1;
        end
      end
    end
  end

endmodule // entry_queue

// file: rtl/host_debug_byte_fifo.v
// Host debug byte capture: timestamped byte queue read by the controller.
`timescale 1ns/1ps
`include "host_debug_byte_fifo_defines.vh"

module host_debug_byte_fifo #(
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire        CLK,
  input  wire        RST,
  input  wire        CE,
  input  wire        HOST_WR,
  input  wire        HOST_RD,
  input  wire [7:0]  HOST_ADDR,
  input  wire [7:0]  HOST_WDATA,
  output reg  [7:0]  HOST_RDATA,
  output reg         HOST_ACK,
  input  wire        CFG_SEL,
  input  wire        CFG_WR,
  input  wire        CFG_RD,
  input  wire [7:0]  CFG_INDEX,
  input  wire [7:0]  CFG_WDATA,
  output reg  [7:0]  CFG_RDATA,
  input  wire        EC_WR,
  input  wire        EC_RD,
  input  wire [11:0] EC_ADDR,
  input  wire [31:0] EC_WDATA,
  output reg  [31:0] EC_RDATA,
  output reg         DEBUG_QUEUE_IRQ
);

  // ----------------------------------------------------------------------
  // State registers.
  // ----------------------------------------------------------------------
  reg        active_reg;      // Block enable.
  reg [1:0]  thr_reg;         // Threshold code.
  reg        timer_en_reg;    // Timestamp counting enable.
  reg [1:0]  tick_rate_choice_reg; // Prescaler selection.
  reg        overrun_reg;     // Sticky overrun flag.
  reg [23:0] entry_time_tag_reg;   // Free-running timestamp.
  reg [5:0]  presc_reg;       // Tick prescaler.

  // ----------------------------------------------------------------------
  // Access decode.
  // ----------------------------------------------------------------------
  // Host byte write to the runtime register, only while active.
  wire host_hit   = (HOST_ADDR == `OFS_HOST_DEBUG_BYTE);
  wire host_wr_in = HOST_WR && host_hit;
  wire host_claim = host_wr_in && active_reg;

  // Controller-side decodes.
  wire ec_entry = (EC_ADDR == `OFS_QUEUED_ENTRY_READ);
  wire ec_setup = (EC_ADDR == `OFS_CAPTURE_SETUP);
  wire ec_flags = (EC_ADDR == `OFS_QUEUE_FLAGS);
  wire ec_count = (EC_ADDR == `OFS_TICK_COUNTER_VALUE);
  wire ec_act   = (EC_ADDR == `OFS_BLOCK_ACTIVATION);

  // Configuration port hit on the activation index.
  // Index 30h decode.
  wire cfg_act  = CFG_SEL && (CFG_INDEX == `IDX_BLOCK_ACTIVATION);

  // Strobes carried in a setup write; they are never stored.
  wire setup_wr    = EC_WR && ec_setup;
  wire flush_req   = setup_wr && EC_WDATA[`BIT_FLUSH];
  wire stamp_clr_a = setup_wr && EC_WDATA[`BIT_STAMP_CLEAR];

  // Counter register writes: zero clears, anything else loads.
  wire count_wr    = EC_WR && ec_count;
  wire count_zero  = (EC_WDATA[31:8] == 24'h000000);
  wire stamp_clr_b = count_wr && count_zero;
  wire stamp_load  = count_wr && !count_zero;
  wire stamp_clr   = stamp_clr_a || stamp_clr_b;

  // ----------------------------------------------------------------------
  // Queue.
  // ----------------------------------------------------------------------
  wire        q_in_ready;     // Queue can take the host entry.
  wire        q_out_valid;    // At least one entry held.
  wire [31:0] q_out_data;     // Oldest entry.
  wire [AW:0] q_level;        // Entries held.
  wire        q_full;         // Queue at capacity.
  wire        ec_pop;         // Controller read removes an entry.
  wire        drop_oldest;    // Host write makes room by discarding.
  wire        q_flush;        // Queue cleared this cycle.

  localparam [AW:0] FULL_LVL = DEPTH[AW:0];

  assign q_full      = (q_level == FULL_LVL);
  assign ec_pop      = EC_RD && ec_entry && q_out_valid;
  assign drop_oldest = host_claim && q_full;
  assign q_flush     = flush_req || !active_reg;

  entry_queue #(
    .WIDTH (32),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_queue (
    .clk       (CLK),
    .rst       (RST),
    .ce        (CE),
    .flush     (q_flush),
    .in_valid  (host_claim),
    .in_ready  (q_in_ready),
    .in_data   ({entry_time_tag_reg, HOST_WDATA}),
    .out_valid (q_out_valid),
    .out_ready (ec_pop || drop_oldest),
    .out_data  (q_out_data),
    .level     (q_level)
  );

  // ----------------------------------------------------------------------
  // Activation register.
  // ----------------------------------------------------------------------
  // The controller path wins when both sides write in the same cycle,
  // so firmware always has the final say over the enable.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      active_reg <= 1'b0;
    end else if (CE) begin
      if (EC_WR && ec_act) begin
        active_reg <= EC_WDATA[`BIT_ACTIVATE];
      end else if (cfg_act && CFG_WR) begin
        active_reg <= CFG_WDATA[`BIT_ACTIVATE];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Setup fields.
  // ----------------------------------------------------------------------
  // These fields are reachable whatever the activate bit says, so
  // firmware can prepare the block before turning it on.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      thr_reg              <= `RST_SETUP_FIELDS;
      timer_en_reg         <= 1'b0;
      tick_rate_choice_reg <= `RST_SETUP_FIELDS;
    end else if (CE) begin
      if (setup_wr) begin
        thr_reg              <= EC_WDATA[`POS_THRESHOLD_HI:`POS_THRESHOLD_LO];
        timer_en_reg         <= EC_WDATA[`BIT_TIMER_ENABLE];
        tick_rate_choice_reg <= EC_WDATA[`POS_TICK_RATE_HI:`POS_TICK_RATE_LO];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Tick prescaler and timestamp counter.
  // ----------------------------------------------------------------------
  reg  [5:0] div_last;        // Terminal count of the prescaler.
  wire       tick;            // One-cycle counter advance.

  // Terminal count chosen by the tick rate field.
  always @* begin
    div_last = `DIV_LAST_8;
    case (tick_rate_choice_reg)
      2'h0: div_last = `DIV_LAST_8;
      2'h1: div_last = `DIV_LAST_16;
      2'h2: div_last = `DIV_LAST_32;
      2'h3: div_last = `DIV_LAST_64;
      default: div_last = `DIV_LAST_8;
    endcase
  end

  // A rate change while counting may shorten one tick period, since a prescaler
  // already at or past the new terminal count ticks at once; the prescaler is not reloaded on a field write.
  assign tick = (presc_reg >= div_last);

  // Prescaler runs only while the block and the timer are both on.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      presc_reg <= 6'h00;
    end else if (CE) begin
      if (!active_reg || !timer_en_reg) begin
        presc_reg <= 6'h00;
      end else if (tick) begin
        presc_reg <= 6'h00;
      end else begin
        presc_reg <= presc_reg + 6'h01;
      end
    end
  end

  // Timestamp: deactivation and clear beat a load, a load beats a tick.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      entry_time_tag_reg <= `RST_STAMP;
    end else if (CE) begin
      if (!active_reg) begin
        entry_time_tag_reg <= `RST_STAMP;
      end else if (stamp_clr) begin
        entry_time_tag_reg <= `RST_STAMP;
      end else if (stamp_load) begin
        entry_time_tag_reg <= EC_WDATA[31:8];
      end else if (timer_en_reg && tick) begin
        entry_time_tag_reg <= entry_time_tag_reg + 24'h000001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Overrun flag.
  // ----------------------------------------------------------------------
  // A write into a full queue in the same cycle as a flush still
  // leaves the flag set, so the loss is never hidden from firmware.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      overrun_reg <= 1'b0;
    end else if (CE) begin
      if (drop_oldest) begin
        overrun_reg <= 1'b1;
      end else if (q_flush) begin
        overrun_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt.
  // ----------------------------------------------------------------------
  reg [AW:0] thr_level;       // Threshold in entries.

  // Threshold code to entry count.
  always @* begin
    thr_level = `THR_LEVEL_0;
    case (thr_reg)
      2'h0: thr_level = `THR_LEVEL_0;
      2'h1: thr_level = `THR_LEVEL_1;
      2'h2: thr_level = `THR_LEVEL_2;
      2'h3: thr_level = `THR_LEVEL_3;
      default: thr_level = `THR_LEVEL_0;
    endcase
  end

  // The interrupt output is registered, so it trails the queue level by one cycle.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      DEBUG_QUEUE_IRQ <= 1'b0;
    end else if (CE) begin
      DEBUG_QUEUE_IRQ <= active_reg && (q_level >= thr_level);
    end
  end

  // ----------------------------------------------------------------------
  // Controller read data.
  // ----------------------------------------------------------------------
  reg [31:0] ec_rd_next;      // Word selected by the address.

  // Read multiplexer; unmapped offsets and reserved bits read zero.
  always @* begin
    ec_rd_next = `RST_WORD;
    case (EC_ADDR)
      `OFS_QUEUED_ENTRY_READ: begin
        ec_rd_next = q_out_valid ? q_out_data : `RST_WORD;
      end
      `OFS_CAPTURE_SETUP: begin
        ec_rd_next[`POS_THRESHOLD_HI:`POS_THRESHOLD_LO] = thr_reg;
        ec_rd_next[`BIT_TIMER_ENABLE] = timer_en_reg;
        ec_rd_next[`POS_TICK_RATE_HI:`POS_TICK_RATE_LO] = tick_rate_choice_reg;
      end
      `OFS_QUEUE_FLAGS: begin
        ec_rd_next[`BIT_HAS_ENTRIES] = q_out_valid;
        ec_rd_next[`BIT_OVERRUN] = overrun_reg;
      end
      `OFS_TICK_COUNTER_VALUE: begin
        ec_rd_next[31:8] = entry_time_tag_reg;
      end
      `OFS_BLOCK_ACTIVATION: begin
        ec_rd_next[`BIT_ACTIVATE] = active_reg;
      end
      default: ec_rd_next = `RST_WORD;
    endcase
  end

  // Read data is captured on the read strobe and held until the next.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      EC_RDATA <= `RST_WORD;
    end else if (CE) begin
      if (EC_RD) begin
        EC_RDATA <= ec_rd_next;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Host and configuration port answers.
  // ----------------------------------------------------------------------
  // Host acknowledge marks a claimed access one cycle after the strobe;
  // the queue's ready gates it so a stalled write is never acknowledged.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      HOST_ACK   <= 1'b0;
      HOST_RDATA <= 8'h00;
    end else if (CE) begin
      HOST_ACK   <= active_reg && host_hit &&
                    ((HOST_WR && q_in_ready) || HOST_RD);
      HOST_RDATA <= 8'h00;
    end
  end

  // Configuration port read of the activation register.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      CFG_RDATA <= 8'h00;
    end else if (CE) begin
      if (CFG_RD) begin
        CFG_RDATA <= cfg_act ? {7'h00, active_reg} : 8'h00;
      end
    end
  end

endmodule // host_debug_byte_fifo

// file: test/host_debug_byte_fifo_asserts.sv
// Port-level checker for the host debug byte capture block.
`timescale 1ns/1ps
module host_debug_byte_fifo_asserts (
  input wire        CLK,
  input wire        RST,
  input wire        CE,
  input wire        HOST_WR,
  input wire        HOST_RD,
  input wire [7:0]  HOST_ADDR,
  input wire [7:0]  HOST_RDATA,
  input wire        HOST_ACK,
  input wire        CFG_SEL,
  input wire        CFG_RD,
  input wire [7:0]  CFG_INDEX,
  input wire [7:0]  CFG_RDATA,
  input wire        EC_WR,
  input wire        EC_RD,
  input wire [11:0] EC_ADDR,
  input wire [31:0] EC_WDATA,
  input wire [31:0] EC_RDATA,
  input wire        DEBUG_QUEUE_IRQ
);
  // ----------------------------------------------------------------
  // Clocking and step sequences.
  // ----------------------------------------------------------------
  // A frozen clock enable stops all state, so checks pause with it.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST || !CE);
  sequence flush_wr;
    EC_WR && EC_ADDR == 12'h104 && EC_WDATA[1] && !HOST_WR;
  endsequence
  sequence quiet_host;
    !HOST_WR;
  endsequence

  a_ack_has_cause:
  assert property (HOST_ACK |-> $past(HOST_WR || HOST_RD) && $past(HOST_ADDR) == 8'h00)
  else $error("host ack without a claimed access");
  a_host_reads_zero:
  assert property (HOST_RDATA == 8'h00)
  else $error("host read data not zero");
  a_flush_drops_irq:
  assert property (flush_wr ##1 quiet_host |=> !DEBUG_QUEUE_IRQ)
  else $error("interrupt survives a flush");
  a_cfg_hit_bits:
  assert property (CFG_RD && CFG_SEL && CFG_INDEX == 8'h30 |=> CFG_RDATA[7:1] == 7'h00)
  else $error("activation read shows reserved bits");
  a_cfg_miss_zero:
  assert property (CFG_RD && !(CFG_SEL && CFG_INDEX == 8'h30) |=> CFG_RDATA == 8'h00)
  else $error("unselected config read not zero");
  a_popped_debug_byte_holds:
  assert property (!EC_RD |=> $stable(EC_RDATA))
  else $error("controller read data moved without a read");
  a_strobes_read_zero:
  assert property (EC_RD && EC_ADDR == 12'h104 |=> EC_RDATA[2:1] == 2'h0)
  else $error("setup strobes read back set");
  a_flags_upper_zero:
  assert property (EC_RD && EC_ADDR == 12'h108 |=> EC_RDATA[31:2] == 30'h0)
  else $error("flag word upper bits set");
  a_unmapped_zero:
  assert property (EC_RD && EC_ADDR == 12'h200 |=> EC_RDATA == 32'h0)
  else $error("unmapped read not zero");
endmodule  // host_debug_byte_fifo_asserts

bind host_debug_byte_fifo host_debug_byte_fifo_asserts i_chk (.CLK, .RST, .CE, .HOST_WR,
  .HOST_RD, .HOST_ADDR, .HOST_RDATA, .HOST_ACK, .CFG_SEL, .CFG_RD, .CFG_INDEX, .CFG_RDATA,
  .EC_WR, .EC_RD, .EC_ADDR, .EC_WDATA, .EC_RDATA, .DEBUG_QUEUE_IRQ);

// file: test/host_cpu_model.sv
// Host processor model for the runtime byte port and the config port.
`timescale 1ns/1ps
module host_cpu_model (
  input  wire       CLK,
  input  wire       HOST_ACK,
  input  wire [7:0] CFG_RDATA,
  output reg        HOST_WR,
  output reg        HOST_RD,
  output reg  [7:0] HOST_ADDR,
  output reg  [7:0] HOST_WDATA,
  output reg        CFG_SEL,
  output reg        CFG_WR,
  output reg        CFG_RD,
  output reg  [7:0] CFG_INDEX,
  output reg  [7:0] CFG_WDATA
);
  // Idle bus at time zero.
  initial begin
    {HOST_WR, HOST_RD, CFG_SEL, CFG_WR, CFG_RD} = 5'h00;
    {HOST_ADDR, HOST_WDATA, CFG_INDEX, CFG_WDATA} = 32'h00000000;
  end
  task host(input logic rd, input logic [7:0] a, input logic [7:0] d, output logic ack);
    @(posedge CLK);
    #1;
    {HOST_RD, HOST_WR, HOST_ADDR, HOST_WDATA} = {rd, !rd, a, d};
    @(posedge CLK);
    #1;
    ack = HOST_ACK;
    {HOST_RD, HOST_WR} = 2'h0;
    // A released data bus shows the inverse, never a stale copy.
    HOST_WDATA = ~d;
  endtask
  task cfg(input logic rd, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    @(posedge CLK);
    #1;
    {CFG_SEL, CFG_RD, CFG_WR, CFG_INDEX, CFG_WDATA} = {1'b1, rd, !rd, idx, d};
    @(posedge CLK);
    #1;
    q = CFG_RDATA;
    {CFG_SEL, CFG_RD, CFG_WR} = 3'h0;
    CFG_WDATA = ~d;
  endtask
endmodule  // host_cpu_model

// file: test/tb.sv
// Self-checking bench for the host debug byte capture block.
`timescale 1ns/1ps
module tb;
  // ----------------------------------------------------------------
  // Signals.
  // ----------------------------------------------------------------
  reg          CLK, RST, CE, EC_WR, EC_RD;    // Clock, reset, enable, controller strobes.
  reg  [11:0]  EC_ADDR;                       // Controller offset.
  reg  [31:0]  EC_WDATA;                      // Controller write word.
  wire         HOST_WR, HOST_RD, HOST_ACK, CFG_SEL, CFG_WR, CFG_RD, DEBUG_QUEUE_IRQ;
  wire [7:0]   HOST_ADDR, HOST_WDATA, HOST_RDATA, CFG_INDEX, CFG_WDATA, CFG_RDATA;
  wire [31:0]  EC_RDATA;                      // Controller read word.
  integer      errors, total_checks, i, c;    // Counters and loop indices.
  logic [31:0] v;                             // Last controller read.
  logic        ack;                           // Last host claim.
  logic [7:0]  q;                             // Last config read.

  // The clock enable is driven so that a frozen cycle can be exercised.
  host_debug_byte_fifo i_dut (.CLK, .RST, .CE, .HOST_WR, .HOST_RD, .HOST_ADDR,
    .HOST_WDATA, .HOST_RDATA, .HOST_ACK, .CFG_SEL, .CFG_WR, .CFG_RD, .CFG_INDEX, .CFG_WDATA,
    .CFG_RDATA, .EC_WR, .EC_RD, .EC_ADDR, .EC_WDATA, .EC_RDATA, .DEBUG_QUEUE_IRQ);
  host_cpu_model i_host (.CLK, .HOST_ACK, .CFG_RDATA, .HOST_WR, .HOST_RD, .HOST_ADDR,
    .HOST_WDATA, .CFG_SEL, .CFG_WR, .CFG_RD, .CFG_INDEX, .CFG_WDATA);

  // 20 MHz clock.
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("unexpected %s: expected %h, seen %h", n, exp, seen);
    end
  endtask
  task ec(input logic rd, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    #1;
    {EC_RD, EC_WR, EC_ADDR, EC_WDATA} = {rd, !rd, a, d};
    @(posedge CLK);
    #1;
    v = EC_RDATA;
    {EC_RD, EC_WR} = 2'h0;
    EC_WDATA = ~d;
  endtask
  task rd_chk(input string n, input logic [11:0] a, input logic [31:0] exp);
    ec(1'b1, a, 32'h0);
    check(n, v, exp);
  endtask
  task tick(input integer n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  function automatic integer thr(input integer k);
    thr = (k == 0) ? 1 : (k == 1) ? 4 : (k == 2) ? 8 : 14;
  endfunction
  task conclude;
    $display("checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog: a hung run counts as a mismatch.
  initial begin
    repeat (50000) @(posedge CLK);
    errors = errors + 1;
    conclude;
  end
  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    total_checks = 0;
    {RST, EC_WR, EC_RD, EC_ADDR, EC_WDATA} = {1'b1, 46'h0};
    CE = 1'b1;
    repeat (12) @(posedge CLK);
    #1;
    RST = 1'b0;
    rd_chk("setup", 12'h104, 32'h0);
    rd_chk("flags", 12'h108, 32'h0);
    rd_chk("activation", 12'h330, 32'h0);
    rd_chk("unmapped", 12'h200, 32'h0);
    // Inactive block must not claim or queue a byte.
    i_host.host(1'b0, 8'h00, 8'hA5, ack);
    check("inactive ack", ack, 0);
    rd_chk("inactive flags", 12'h108, 32'h0);
    i_host.cfg(1'b0, 8'h30, 8'h01, q);
    rd_chk("activation", 12'h330, 32'h1);
    i_host.cfg(1'b1, 8'h30, 8'h00, q);
    check("cfg read", q, 32'h1);
    i_host.cfg(1'b1, 8'h31, 8'h00, q);
    check("cfg miss", q, 32'h0);
    // Strobes written as one read back as zero.
    ec(1'b0, 12'h104, 32'h86);
    rd_chk("setup", 12'h104, 32'h80);
    ec(1'b0, 12'h10C, 32'h00012300);
    rd_chk("count", 12'h10C, 32'h00012300);
    i_host.host(1'b1, 8'h00, 8'h00, ack);
    check("host read ack", ack, 1);
    check("host rdata", HOST_RDATA, 32'h0);
    i_host.host(1'b0, 8'h04, 8'h77, ack);
    check("other offset", ack, 0);
    i_host.host(1'b0, 8'h00, 8'h5A, ack);
    check("ack", ack, 1);
    rd_chk("flags", 12'h108, 32'h1);
    rd_chk("entry", 12'h100, 32'h0001235A);
    rd_chk("empty pop", 12'h100, 32'h0);
    rd_chk("count held", 12'h10C, 32'h00012300);
    // A low clock enable freezes the block: no claim and nothing queued.
    CE = 1'b0;
    i_host.host(1'b0, 8'h00, 8'h3C, ack);
    CE = 1'b1;
    check("frozen ack", ack, 0);
    rd_chk("frozen flags", 12'h108, 32'h0);
    // Fill past full, sweeping every threshold code at each level.
    for (i = 1; i <= 17; i++) begin
      i_host.host(1'b0, 8'h00, i[7:0], ack);
      for (c = 0; c < 4; c++) begin
        ec(1'b0, 12'h104, c << 6);
        tick(1);
        check("irq", DEBUG_QUEUE_IRQ, (i >= thr(c)));
      end
    end
    rd_chk("overrun", 12'h108, 32'h3);
    rd_chk("oldest dropped", 12'h100, 32'h00012302);
    ec(1'b0, 12'h104, 32'hC2);
    rd_chk("flushed", 12'h108, 32'h0);
    ec(1'b0, 12'h330, 32'h0);
    rd_chk("setup kept", 12'h104, 32'hC0);
    rd_chk("count reset", 12'h10C, 32'h0);
    // Each rate: clear by zero write, then count 16 ticks within one tick.
    ec(1'b0, 12'h330, 32'h1);
    for (c = 0; c < 4; c++) begin
      ec(1'b0, 12'h104, 32'h20 | (c << 3));
      ec(1'b0, 12'h10C, 32'h0);
      tick(16 << (c + 3));
      ec(1'b1, 12'h10C, 32'h0);
      check("tick rate", v[31:8] >= 15 && v[31:8] <= 17, 1);
    end
    ec(1'b0, 12'h104, 32'h18);
    ec(1'b1, 12'h10C, 32'h0);
    tick(100);
    rd_chk("timer stopped", 12'h10C, v);
    ec(1'b0, 12'h104, 32'h1C);
    rd_chk("stamp clear", 12'h10C, 32'h0);
    conclude;
  end
endmodule  // tb
